//--- shared/dgc_pkg.sv
// Constants and types shared by the general configuration and status register group.
// Behaviour
// R1 - Step-toggle bit makes marker toggle per step.
// R2 - Power-down pin ignored when disable bit set.
// R3 - Resolution from pins or register field.
// R4 - Step filter bit resets to one.
// R5 - Filtered period shown above about 750 Hz.
// R6 - Test bit drives probe, forces enable.
// R7 - Host keeps test bit at zero.
// R8 - Writing one clears a status flag.
// R9 - Reset flag set after any reset.
// R10 - Driver error latches on power stage shutdown.
// R11 - Driver error clear ignored while fault persists.
// R12 - Undervoltage flag reports charge pump undervoltage.
// R13 - Undervoltage flag follows live condition.
// R14 - Counter increments on each accepted write.
// R15 - Reads leave the counter unchanged.
// R16 - Counter wraps from 255 to zero.
// R17 - Reply wait code pairs give 8..72 bits.
// R18 - Upper codes give 88, 104, 120 bits.
// R19 - Host adds 0x80 to address for writes.
// R20 - Marker source: first microstep or prewarning.
// R21 - Registers reset to zero unless noted; the code also resets config bit 0 to one.
// R22 - Reply wait starts after request stop bit.
package dgc_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned FULLSTEP_HZ_MIN = 750;
    localparam int unsigned PERIOD_W        = 20;
    // Full-step period, in clock cycles, below which optimization engages.
    localparam logic [PERIOD_W-1:0] FULLSTEP_CYC_MAX =
        PERIOD_W'(CLK_HZ / FULLSTEP_HZ_MIN);

    // ----------------------------------------------------------------
    // Register offsets and access marking
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W          = 7;
    localparam int unsigned DATA_W          = 32;
    localparam logic [6:0] OFS_GLOBAL_CONFIG_FLAGS    = 7'h00;
    localparam logic [6:0] OFS_GLOBAL_STATUS_FLAGS    = 7'h01;
    localparam logic [6:0] OFS_WRITE_TRANSFER_COUNTER = 7'h02;
    localparam logic [6:0] OFS_REPLY_DELAY_CONFIG     = 7'h03;
    localparam int unsigned WRITE_MARK_BIT  = 7;

    // ----------------------------------------------------------------
    // Field layouts and reset values
    // ----------------------------------------------------------------
    localparam int unsigned CFG_W             = 10;
    localparam int unsigned BIT_INDEX_OTPW    = 4;
    localparam int unsigned BIT_INDEX_STEP    = 5;
    localparam int unsigned BIT_PDN_DISABLE   = 6;
    localparam int unsigned BIT_MSTEP_REG_SEL = 7;
    localparam int unsigned BIT_MULTISTEP_FILT = 8;
    localparam int unsigned BIT_TEST_MODE     = 9;
    localparam logic [CFG_W-1:0] CFG_RESET    = 10'h101;
    localparam int unsigned STAT_W            = 3;
    localparam int unsigned BIT_RESET_FLAG    = 0;
    localparam int unsigned BIT_DRV_ERR       = 1;
    localparam int unsigned BIT_PUMP_UV       = 2;
    localparam int unsigned CNT_W             = 8;
    localparam int unsigned WAIT_W            = 4;
    localparam int unsigned WAIT_LSB          = 8;
    localparam int unsigned WAIT_CNT_W        = 7;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TMR_IDLE = 2'b01,
        TMR_WAIT = 2'b10
    } dgc_tmr_e;

    // Bit times before a reply: codes pair up as (2k+1)*8.
    function automatic logic [WAIT_CNT_W-1:0] dgc_reply_bits(input logic [WAIT_W-1:0] code);
        return {code[3:1], 1'b1, 3'h0};
    endfunction : dgc_reply_bits

endpackage : dgc_pkg

//--- core/dgc_reply_timer.sv
// Reply wait timer that delays a read reply by a programmed number of bit times.
`timescale 1ns/1ps
module dgc_reply_timer
    import dgc_pkg::*;
(
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    input  wire logic              start_in,
    input  wire logic [WAIT_W-1:0] code_in,
    input  wire logic              bit_tick_in,
    output logic                   reply_start_out,
    output logic                   waiting_out
);

    typedef struct packed {
        dgc_tmr_e              state;
        logic [WAIT_CNT_W-1:0] cnt;
        logic                  fire;
    } dgc_tmr_s;

    dgc_tmr_s s_q;
    dgc_tmr_s s_d;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // A new request restarts the wait, so a reply never overlaps a request.
    always_comb begin
        s_d      = s_q;
        s_d.fire = 1'b0;
        case (s_q.state)
            TMR_IDLE: begin
                s_d.cnt = '0;
            end
            TMR_WAIT: begin
                if (bit_tick_in) begin
                    if (s_q.cnt == WAIT_CNT_W'(1)) begin
                        s_d.fire  = 1'b1; // [R22]
                        s_d.state = TMR_IDLE;
                    end else begin
                        s_d.cnt = s_q.cnt - WAIT_CNT_W'(1);
                    end
                end
            end
            default: begin
                s_d.state = TMR_IDLE;
            end
        endcase
        if (start_in) begin
            s_d.state = TMR_WAIT;
            s_d.cnt   = dgc_reply_bits(code_in); // [R17] [R18]
            s_d.fire  = 1'b0;
        end
    end

    // Synchronous reset returns the timer to idle.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_q <= '{state: TMR_IDLE, cnt: '0, fire: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign reply_start_out = s_q.fire;
    assign waiting_out     = (s_q.state == TMR_WAIT);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_wait_load;
        @(posedge ref_clk_in) disable iff (rst_in)
        start_in |=> (s_q.cnt == {$past(code_in[3:1]), 1'b1, 3'h0}) && waiting_out;
    endproperty
    a_wait_load: assert property (p_wait_load) else $error("wait count not loaded"); // [R17]

    property p_fire_cause;
        @(posedge ref_clk_in) disable iff (rst_in)
        reply_start_out |-> $past(bit_tick_in) && ($past(s_q.cnt) == 7'h01) && !waiting_out;
    endproperty
    a_fire_cause: assert property (p_fire_cause) else $error("reply started early"); // [R22]

    property p_top_code;
        @(posedge ref_clk_in) disable iff (rst_in)
        (start_in && code_in == 4'hf) |=> s_q.cnt == 7'h78;
    endproperty
    a_top_code: assert property (p_top_code) else $error("top code not 120 bits"); // [R18]

endmodule : dgc_reply_timer

//--- core/dgc_regs.sv
// General configuration and status register group with its pin-facing control outputs.
`timescale 1ns/1ps
module dgc_regs
    import dgc_pkg::*;
#(
    parameter logic [PERIOD_W-1:0] FULLSTEP_CYC_LIMIT = FULLSTEP_CYC_MAX
)
(
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    // Decoded serial access, one pulse per frame accepted at its stop bit.
    input  wire logic                acc_valid_in,
    input  wire logic [7:0]          acc_addr_in,
    input  wire logic [DATA_W-1:0]   acc_wdata_in,
    input  wire logic                bit_tick_in,
    output logic [DATA_W-1:0]        rd_data_out,
    output logic                     reply_start_out,
    output logic                     reply_wait_out,
    // Device conditions.
    input  wire logic                drv_fault_in,
    input  wire logic                pump_undervoltage_in,
    input  wire logic                step_in,
    input  wire logic                first_microstep_in,
    input  wire logic                otpw_in,
    input  wire logic                pdn_uart_pin_in,
    input  wire logic                resolution_pin_a_in,
    input  wire logic                resolution_pin_b_in,
    input  wire logic [1:0]          resolution_field_in,
    input  wire logic                driver_enable_low_pin_in,
    input  wire logic [4:0]          hold_current_field_in,
    input  wire logic [PERIOD_W-1:0] fullstep_period_in,
    input  wire logic [PERIOD_W-1:0] raw_step_period_in,
    input  wire logic [PERIOD_W-1:0] filt_step_period_in,
    // Control outputs.
    output logic                     index_out,
    output logic                     standstill_request_out,
    output logic [1:0]               resolution_out,
    output logic                     step_filter_en_out,
    output logic                     pulse_opt_active_out,
    output logic [PERIOD_W-1:0]      step_period_readout_out,
    output logic                     driver_enabled_out,
    output logic                     analog_probe_oe_out,
    output logic [1:0]               analog_probe_select_out,
    output logic                     enable_pulldown_on_out,
    output logic [CFG_W-1:0]         global_config_out
);

    typedef struct packed {
        logic [CFG_W-1:0]    cfg;
        logic                rst_flag;
        logic                drv_err;
        logic [CNT_W-1:0]    xfer_cnt;
        logic [WAIT_W-1:0]   wait_code;
        logic [DATA_W-1:0]   rd_data;
        logic                index;
        logic                stby;
        logic [1:0]          res;
        logic                opt;
        logic [PERIOD_W-1:0] period;
        logic                drv_en;
        logic                probe_oe;
        logic [1:0]          probe_sel;
    } dgc_regs_s;

    localparam dgc_regs_s S_RESET = '{
        cfg:      CFG_RESET,
        rst_flag: 1'b1,
        default:  '0
    };

    dgc_regs_s        s_q;
    dgc_regs_s        s_d;
    logic             wr_acc;
    logic             rd_acc;
    logic [6:0]       reg_addr;
    logic [STAT_W-1:0] stat_view;

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    // The write mark sits in the top address bit; the rest is the offset.
    assign wr_acc   = acc_valid_in && acc_addr_in[WRITE_MARK_BIT];  // [R19]
    assign rd_acc   = acc_valid_in && !acc_addr_in[WRITE_MARK_BIT]; // [R19]
    assign reg_addr = acc_addr_in[6:0];

    // Live undervoltage is merged at read time rather than stored.
    assign stat_view = {pump_undervoltage_in, s_q.drv_err, s_q.rst_flag}; // [R12] [R13]

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // Register writes.
        if (wr_acc) begin
            s_d.xfer_cnt = s_q.xfer_cnt + CNT_W'(1); // [R14] [R16]
            if (reg_addr == OFS_GLOBAL_CONFIG_FLAGS) begin
                s_d.cfg = acc_wdata_in[CFG_W-1:0];
            end else if (reg_addr == OFS_GLOBAL_STATUS_FLAGS) begin
                if (acc_wdata_in[BIT_RESET_FLAG]) begin
                    s_d.rst_flag = 1'b0; // [R8]
                end
                if (acc_wdata_in[BIT_DRV_ERR]) begin
                    s_d.drv_err = 1'b0; // [R8]
                end
            end else if (reg_addr == OFS_REPLY_DELAY_CONFIG) begin
                s_d.wait_code = acc_wdata_in[WAIT_LSB +: WAIT_W];
            end
        end

        // A present fault sets the flag and overrides any clear in the same cycle.
        if (drv_fault_in) begin
            s_d.drv_err = 1'b1; // [R10] [R11]
        end

        // Read data is captured at the request; reads never touch the counter.
        if (rd_acc) begin
            if (reg_addr == OFS_GLOBAL_CONFIG_FLAGS) begin
                s_d.rd_data = {{(DATA_W-CFG_W){1'b0}}, s_q.cfg};
            end else if (reg_addr == OFS_GLOBAL_STATUS_FLAGS) begin
                s_d.rd_data = {{(DATA_W-STAT_W){1'b0}}, stat_view};
            end else if (reg_addr == OFS_WRITE_TRANSFER_COUNTER) begin
                s_d.rd_data = {{(DATA_W-CNT_W){1'b0}}, s_q.xfer_cnt}; // [R15]
            end else begin
                s_d.rd_data = '0;
            end
        end

        // Position marker source.
        if (s_q.cfg[BIT_INDEX_STEP]) begin
            if (step_in) begin
                s_d.index = !s_q.index; // [R1]
            end
        end else if (s_q.cfg[BIT_INDEX_OTPW]) begin
            s_d.index = otpw_in; // [R20]
        end else begin
            s_d.index = first_microstep_in; // [R20]
        end

        // Standstill reduction is owned by the pin unless it is disabled.
        s_d.stby = s_q.cfg[BIT_PDN_DISABLE] ? 1'b0 : pdn_uart_pin_in; // [R2]

        // Microstep resolution source.
        if (s_q.cfg[BIT_MSTEP_REG_SEL]) begin
            s_d.res = resolution_field_in; // [R3]
        end else begin
            s_d.res = {resolution_pin_b_in, resolution_pin_a_in}; // [R3]
        end

        // Pulse train optimization only when filtering is on and fast enough.
        s_d.opt = s_q.cfg[BIT_MULTISTEP_FILT] &&
                  (fullstep_period_in < FULLSTEP_CYC_LIMIT); // [R5]
        s_d.period = s_d.opt ? filt_step_period_in : raw_step_period_in; // [R5]

        // Test mode forces enable and exposes the analog probe.
        // Probe pin sharing with the enable input is a hazard in normal use.
        s_d.probe_oe  = s_q.cfg[BIT_TEST_MODE]; // [R6]
        s_d.probe_sel = s_q.cfg[BIT_TEST_MODE] ? hold_current_field_in[1:0] : 2'h0; // [R6]
        s_d.drv_en    = s_q.cfg[BIT_TEST_MODE] ? 1'b1 : !driver_enable_low_pin_in; // [R6]
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Every reset restores defaults and raises the reset flag.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_q <= S_RESET; // [R4] [R9] [R21]
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Reply timing
    // ----------------------------------------------------------------
    // The wait is counted from the accepted read request onward.
    dgc_reply_timer dgc_reply_timer_i (
        .ref_clk_in      (ref_clk_in),
        .rst_in          (rst_in),
        .start_in        (rd_acc),
        .code_in         (s_q.wait_code),
        .bit_tick_in     (bit_tick_in),
        .reply_start_out (reply_start_out),
        .waiting_out     (reply_wait_out)
    ); // [R22]

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rd_data_out             = s_q.rd_data;
    assign index_out               = s_q.index;
    assign standstill_request_out  = s_q.stby;
    assign resolution_out          = s_q.res;
    assign step_filter_en_out      = s_q.cfg[BIT_MULTISTEP_FILT]; // [R4]
    assign pulse_opt_active_out    = s_q.opt;
    assign step_period_readout_out = s_q.period;
    assign driver_enabled_out      = s_q.drv_en;
    assign analog_probe_oe_out     = s_q.probe_oe;
    assign analog_probe_select_out = s_q.probe_sel;
    assign enable_pulldown_on_out  = !s_q.probe_oe; // [R6]
    assign global_config_out       = s_q.cfg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_index_toggle;
        @(posedge ref_clk_in) disable iff (rst_in)
        (s_q.cfg[BIT_INDEX_STEP] && step_in) |=> (index_out != $past(index_out));
    endproperty
    a_index_toggle: assert property (p_index_toggle) else $error("marker missed step"); // [R1]

    property p_standstill;
        @(posedge ref_clk_in) disable iff (rst_in)
        s_q.cfg[BIT_PDN_DISABLE] |=> !standstill_request_out;
    endproperty
    a_standstill: assert property (p_standstill) else $error("pin not ignored"); // [R2]

    property p_res_pins;
        @(posedge ref_clk_in) disable iff (rst_in)
        !s_q.cfg[BIT_MSTEP_REG_SEL] |=>
            resolution_out == {$past(resolution_pin_b_in), $past(resolution_pin_a_in)};
    endproperty
    a_res_pins: assert property (p_res_pins) else $error("resolution not from pins"); // [R3]

    property p_filt_reset;
        @(posedge ref_clk_in)
        $past(rst_in) |-> step_filter_en_out && s_q.rst_flag && s_q.xfer_cnt == 8'h00;
    endproperty
    a_filt_reset: assert property (p_filt_reset) else $error("bad reset values"); // [R4]

    property p_readout;
        @(posedge ref_clk_in) disable iff (rst_in)
        (!s_q.cfg[BIT_MULTISTEP_FILT]) |=>
            !pulse_opt_active_out && step_period_readout_out == $past(raw_step_period_in);
    endproperty
    a_readout: assert property (p_readout) else $error("readout filtered when off"); // [R5]

    property p_test;
        @(posedge ref_clk_in) disable iff (rst_in)
        s_q.cfg[BIT_TEST_MODE] |=> driver_enabled_out && !enable_pulldown_on_out;
    endproperty
    a_test: assert property (p_test) else $error("test mode not forced"); // [R6]

    property p_w1c_zero;
        @(posedge ref_clk_in) disable iff (rst_in)
        (wr_acc && reg_addr == OFS_GLOBAL_STATUS_FLAGS && !acc_wdata_in[BIT_RESET_FLAG]
            && s_q.rst_flag) |=> s_q.rst_flag;
    endproperty
    a_w1c_zero: assert property (p_w1c_zero) else $error("zero write cleared flag"); // [R8]

    property p_drv_err;
        @(posedge ref_clk_in) disable iff (rst_in)
        drv_fault_in |=> s_q.drv_err;
    endproperty
    a_drv_err: assert property (p_drv_err) else $error("driver error cleared early"); // [R11]

    property p_uv_live;
        @(posedge ref_clk_in) disable iff (rst_in)
        (rd_acc && reg_addr == OFS_GLOBAL_STATUS_FLAGS) |=>
            rd_data_out[BIT_PUMP_UV] == $past(pump_undervoltage_in);
    endproperty
    a_uv_live: assert property (p_uv_live) else $error("undervoltage not live"); // [R13]

    property p_cnt_inc;
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_acc |=> s_q.xfer_cnt == 8'($past(s_q.xfer_cnt) + 8'h01);
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step"); // [R14]

    property p_cnt_read;
        @(posedge ref_clk_in) disable iff (rst_in)
        !wr_acc |=> $stable(s_q.xfer_cnt);
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("counter moved on read"); // [R15]

endmodule : dgc_regs

//--- tb/dgc_host_model.sv
// Host model that issues decoded register accesses and paces serial bit times.
`timescale 1ns/1ps
module dgc_host_model
    import dgc_pkg::*;
#(
    parameter int TICK_DIV = 3
)(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    output logic             acc_valid_out,
    output logic [7:0]       acc_addr_out,
    output logic [31:0]      acc_wdata_out,
    output logic             bit_tick_out
);
    // ----------------------------------------------------------------
    // Bit time pacing
    // ----------------------------------------------------------------
    int tick_cnt;
    bit allow_test = 1'b0;

    // One tick per bit time; a slow divider keeps reply waits easy to count.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || tick_cnt == TICK_DIV - 1)
            tick_cnt <= 0;
        else
            tick_cnt <= tick_cnt + 1;
        bit_tick_out <= !rst_in && (tick_cnt == TICK_DIV - 1);
    end

    // Idle values at time zero so the block never sees an unknown request.
    initial begin
        acc_valid_out = 1'b0;
        acc_addr_out  = 8'h00;
        acc_wdata_out = 32'h0;
    end

    // ----------------------------------------------------------------
    // One access, held until the edge that takes it
    // ----------------------------------------------------------------
    // Released lines show the inverse so a stale value is never mistaken for data.
    task automatic access(input logic wr, input logic [6:0] ofs, input logic [31:0] data);
        logic [31:0] wd;
        wd = data;
        if (wr && ofs == OFS_GLOBAL_CONFIG_FLAGS && !allow_test)
            wd[BIT_TEST_MODE] = 1'b0; // A normal host never sets the test bit.
        @(posedge ref_clk_in);
        acc_valid_out <= 1'b1;
        acc_addr_out  <= {wr, ofs}; // Writes carry 0x80 on top of the offset.
        acc_wdata_out <= wd;
        @(posedge ref_clk_in);
        acc_valid_out <= 1'b0;
        acc_addr_out  <= ~{wr, ofs};
        acc_wdata_out <= ~wd;
        #1;
    endtask : access
endmodule : dgc_host_model

//--- tb/driver_general_config_status_tb_top.sv
// Self-checking testbench for the general configuration and status register group.
`timescale 1ns/1ps
module driver_general_config_status_tb_top
    import dgc_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic ref_clk_in, rst_in, valid, tick, rs, rw, flt, uv, stp, fms, otpw, pdn, rpa, rpb, enl;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  rfield, res, psel;
    logic [4:0]  hold;
    logic [19:0] fsp, raw, filt, rdout;
    logic [9:0]  cfg;
    logic idx, ss, fen, opt, den, poe, pdo;
    wire  [10:0] ctl = {ss, res, idx, fen, opt, den, poe, psel, pdo};
    int miscompares = 0;
    int num_checks = 0;
    int wr_count = 0;

    dgc_host_model #(.TICK_DIV(3)) dgc_host_model_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .acc_valid_out(valid), .acc_addr_out(addr), .acc_wdata_out(wdata), .bit_tick_out(tick));

    dgc_regs #(.FULLSTEP_CYC_LIMIT(20'd100)) dgc_regs_i (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .acc_valid_in(valid), .acc_addr_in(addr), .acc_wdata_in(wdata),
        .bit_tick_in(tick), .rd_data_out(rdata), .reply_start_out(rs), .reply_wait_out(rw),
        .drv_fault_in(flt), .pump_undervoltage_in(uv), .step_in(stp),
        .first_microstep_in(fms), .otpw_in(otpw), .pdn_uart_pin_in(pdn),
        .resolution_pin_a_in(rpa), .resolution_pin_b_in(rpb), .resolution_field_in(rfield),
        .driver_enable_low_pin_in(enl), .hold_current_field_in(hold),
        .fullstep_period_in(fsp), .raw_step_period_in(raw), .filt_step_period_in(filt),
        .index_out(idx), .standstill_request_out(ss), .resolution_out(res),
        .step_filter_en_out(fen), .pulse_opt_active_out(opt), .step_period_readout_out(rdout),
        .driver_enabled_out(den), .analog_probe_oe_out(poe), .analog_probe_select_out(psel),
        .enable_pulldown_on_out(pdo), .global_config_out(cfg));

    // Free-running 50 MHz clock.
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [6:0] ofs, output logic [31:0] v);
        dgc_host_model_i.access(1'b0, ofs, 32'h0);
        v = rdata;
    endtask : rd

    task automatic wr(input logic [6:0] ofs, input logic [31:0] v);
        dgc_host_model_i.access(1'b1, ofs, v);
        wr_count++;
    endtask : wr

    // Controls follow their cause one cycle later.
    task automatic settle();
        @(posedge ref_clk_in);
        #1;
    endtask : settle

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(OFS_GLOBAL_CONFIG_FLAGS, d); chk(d, 32'h101);
        rd(OFS_GLOBAL_STATUS_FLAGS, d); chk(d, 32'h1);
        rd(OFS_REPLY_DELAY_CONFIG, d); chk(d, 32'h0);
        rd(OFS_WRITE_TRANSFER_COUNTER, d); chk(d, 32'h0);
    endtask : t_reset

    // Latched flags, a clear refused while the fault stands, and the live undervoltage.
    task automatic t_status();
        wr(OFS_GLOBAL_STATUS_FLAGS, 32'h0); rd(OFS_GLOBAL_STATUS_FLAGS, d); chk(d, 32'h1);
        wr(OFS_GLOBAL_STATUS_FLAGS, 32'h1); rd(OFS_GLOBAL_STATUS_FLAGS, d); chk(d, 32'h0);
        @(posedge ref_clk_in) flt <= 1'b1;
        @(posedge ref_clk_in) flt <= 1'b0;
        rd(OFS_GLOBAL_STATUS_FLAGS, d); chk(d, 32'h2);
        @(posedge ref_clk_in) flt <= 1'b1;
        wr(OFS_GLOBAL_STATUS_FLAGS, 32'h2); rd(OFS_GLOBAL_STATUS_FLAGS, d); chk(d, 32'h2);
        @(posedge ref_clk_in) flt <= 1'b0;
        wr(OFS_GLOBAL_STATUS_FLAGS, 32'h2); rd(OFS_GLOBAL_STATUS_FLAGS, d); chk(d, 32'h0);
        @(posedge ref_clk_in) uv <= 1'b1;
        settle();
        rd(OFS_GLOBAL_STATUS_FLAGS, d); chk(d, 32'h4);
        @(posedge ref_clk_in) uv <= 1'b0;
        settle();
        rd(OFS_GLOBAL_STATUS_FLAGS, d); chk(d, 32'h0);
    endtask : t_status

    // Writes anywhere count, even to the counter itself or an unmapped offset.
    task automatic t_counter();
        rd(OFS_WRITE_TRANSFER_COUNTER, d); chk(d, 32'(wr_count % 256));
        wr(7'h05, 32'h1); rd(7'h05, d); chk(d, 32'h0);
        while (wr_count % 256 != 255)
            wr(OFS_WRITE_TRANSFER_COUNTER, 32'h0);
        rd(OFS_WRITE_TRANSFER_COUNTER, d); chk(d, 32'hff);
        wr(OFS_WRITE_TRANSFER_COUNTER, 32'h0);
        rd(OFS_WRITE_TRANSFER_COUNTER, d); chk(d, 32'h0);
    endtask : t_counter

    task automatic t_config();
        logic i0;
        wr(OFS_GLOBAL_CONFIG_FLAGS, 32'h0); settle();
        chk({rdout, ctl}, {20'h11111, 11'b1_01_1_0_0_0_0_00_1});
        wr(OFS_GLOBAL_CONFIG_FLAGS, 32'h1d0); settle();
        chk({rdout, ctl}, {20'h22222, 11'b0_11_0_1_1_0_0_00_1});
        @(posedge ref_clk_in) fsp <= 20'd200;
        settle();
        chk({rdout, ctl}, {20'h11111, 11'b0_11_0_1_0_0_0_00_1});
        wr(OFS_GLOBAL_CONFIG_FLAGS, 32'h020); settle();
        i0 = idx;
        @(posedge ref_clk_in) stp <= 1'b1;
        @(posedge ref_clk_in) stp <= 1'b0;
        settle();
        chk(idx, !i0);
        dgc_host_model_i.allow_test = 1'b1;
        wr(OFS_GLOBAL_CONFIG_FLAGS, 32'h200); settle();
        chk({rdout, ctl}, {20'h11111, 11'b1_01_1_0_0_1_1_10_0});
        dgc_host_model_i.allow_test = 1'b0;
        wr(OFS_GLOBAL_CONFIG_FLAGS, 32'h200); settle();
        chk(cfg, 32'h0);
    endtask : t_config

    // Every wait code, ticks counted from the cycle after the request.
    task automatic t_delay();
        int n;
        int k;
        int cnt0;
        cnt0 = wr_count;
        for (int c = 0; c < 16; c++) begin
            wr(OFS_REPLY_DELAY_CONFIG, 32'(c) << 8);
            rd(OFS_REPLY_DELAY_CONFIG, d); chk(d, 32'h0);
            n = 0;
            for (k = 0; k < 1000 && rs !== 1'b1; k++) begin
                @(negedge ref_clk_in);
                n += int'(tick === 1'b1 && rw === 1'b1);
            end
            if (k >= 1000) begin
                miscompares++;
                $display("[ERR] %0t reply never started", $time);
                give_verdict();
            end
            chk(32'(n), 32'((2 * (c / 2) + 1) * 8));
        end
        rd(OFS_WRITE_TRANSFER_COUNTER, d); chk(d, 32'((cnt0 + 16) % 256));
    endtask : t_delay

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_in, flt, uv, stp, fms, otpw, pdn, rpa, rpb, enl} = 10'b1000101101;
        rfield = 2'b11;
        hold = 5'h02;
        fsp = 20'd50;
        raw = 20'h11111;
        filt = 20'h22222;
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_status();
        t_counter();
        t_config();
        t_delay();
        give_verdict();
    end
endmodule : driver_general_config_status_tb_top
